// ==== dbs_pkg.sv ====
// Package for the burst-of-two DDR SRAM command and write-mask core
`default_nettype none
package dbs_pkg;
  // Widths: x36 uses 4 byte masks, x18 two, x8 two nybble masks
  localparam int unsigned WIDTH_X36   = 36;
  localparam int unsigned WIDTH_X18   = 18;
  localparam int unsigned WIDTH_X8    = 8;
  localparam int unsigned LANE_BYTE   = 9;
  localparam int unsigned LANE_NYBBLE = 4;
  // Read latency in full cycles from command edge to first beat
  localparam int unsigned READ_LAT    = 2;
  // Turnaround: drivers off 2.5 cycles after a nop or write, modelled as cycle n+2 half-rate slot
  localparam int unsigned TURN_LAT    = 2;
  localparam logic [1:0]  PIPE_RST    = 2'h0;
  typedef enum logic [1:0] {
    DBS_IDLE  = 2'b00,
    DBS_WBEAT = 2'b01,
    DBS_WCOMM = 2'b11
  } dbs_wstate_t;
endpackage : dbs_pkg
`default_nettype wire

// ==== dbs_core.sv ====
// Burst-of-two DDR SRAM core: command decode, burst pipeline, masked writes
// Function
// - Load low, read high accepts read
// - Load low, read low accepts write
// - Load high is deselect, no address load
// - Read data beats at n+2, n+2.5
// - Double-width row holds both beats, no second address
// - Termination low: drivers off after nop/write
// - Termination high: drivers also off likewise
// - Masks sampled per beat, low lane stores
// - All masks high both beats aborts write
// - x36 four byte masks gate nine bits
// - x18 two byte masks gate nine bits
// - x8 nybble masks gate four bits
// - Nybble masks follow same beat rules
// - Accepted bursts always finish both beats
// - Deselect after read waits for beats
// - Masked lane keeps stored contents
`timescale 1ns/1ps
`default_nettype none
module dbs_core #(
  parameter int unsigned DATA_W = dbs_pkg::WIDTH_X36,
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Beat phase: low marks the positive-clock half, high the negative-clock half
  input  wire logic                 beat_phase,
  input  wire logic                 load_n,
  input  wire logic                 read_not_write,
  input  wire logic [ADDR_W-1:0]    addr,
  // Lane count spelled out here: body localparams are not yet visible in the port list
  input  wire logic [DATA_W/((DATA_W == dbs_pkg::WIDTH_X8) ? dbs_pkg::LANE_NYBBLE : dbs_pkg::LANE_BYTE)-1:0]
                                    byte_write_mask_n,
  input  wire logic                 termination_select,
  input  wire logic [DATA_W-1:0]    dq_in,
  output logic      [DATA_W-1:0]    dq_out,
  output logic                      dq_oe,
  output logic                      dq_term_active
);
  // x8 uses nybble lanes, wider parts byte lanes
  localparam int unsigned LANE_W = (DATA_W == dbs_pkg::WIDTH_X8) ? dbs_pkg::LANE_NYBBLE : dbs_pkg::LANE_BYTE;
  localparam int unsigned MASK_W = DATA_W / LANE_W;
  localparam int unsigned DEPTH  = 1 << ADDR_W;

  // Double-width array: one row holds both beats
  logic [2*DATA_W-1:0] mem [DEPTH];

  // Internal fast clock: two half-cycle slots per command cycle
  wire logic cmd_edge = ~beat_phase;
  wire logic cmd_read  = cmd_edge & ~load_n & read_not_write;
  wire logic cmd_write = cmd_edge & ~load_n & ~read_not_write;
  wire logic cmd_idle  = cmd_edge & load_n;

  // Read pipeline: slots 0..4 half cycles
  logic [4:0]            rd_pipe_reg, rd_pipe_next;
  logic [ADDR_W-1:0]     rd_addr_reg, rd_addr_next;
  logic [2*DATA_W-1:0]   rd_row_reg, rd_row_next;
  // Output row: a back-to-back read fetches over rd_row while beats still run
  logic [2*DATA_W-1:0]   out_row_reg, out_row_next;
  logic [DATA_W-1:0]     dq_out_reg, dq_out_next;
  logic                  dq_oe_reg, dq_oe_next;
  logic [4:0]            off_pipe_reg, off_pipe_next;

  // Write pipeline
  dbs_pkg::dbs_wstate_t  ws_reg, ws_next;
  logic [ADDR_W-1:0]     wr_addr_reg, wr_addr_next;
  logic [1:0]            wr_wait_reg, wr_wait_next;
  logic [DATA_W-1:0]     beat0_reg, beat0_next;
  logic [MASK_W-1:0]     mask0_reg, mask0_next;
  logic                  commit_reg, commit_next;
  logic [2*DATA_W-1:0]   commit_data_reg, commit_data_next;
  logic [2*DATA_W-1:0]   commit_bits_reg, commit_bits_next;
  logic [ADDR_W-1:0]     commit_addr_reg, commit_addr_next;
  // Write landing on the first-beat slot waits here until the commit slot
  logic                  pend_reg, pend_next;
  logic [ADDR_W-1:0]     pend_addr_reg, pend_addr_next;

  // Lane expansion of active-low masks into bit enables
  function automatic logic [DATA_W-1:0] lane_en(input logic [MASK_W-1:0] m_n);
    logic [DATA_W-1:0] e;
    e = '0;
    for (int i = 0; i < int'(DATA_W); i++) begin
      e[i] = ~m_n[i / int'(LANE_W)];
    end
    return e;
  endfunction : lane_en

  always_comb begin
    rd_pipe_next  = {rd_pipe_reg[3:0], 1'b0};
    rd_addr_next  = rd_addr_reg;
    rd_row_next   = rd_row_reg;
    out_row_next  = out_row_reg;
    dq_out_next   = dq_out_reg;
    off_pipe_next = {off_pipe_reg[3:0], 1'b0};
    if (cmd_read) begin
      rd_pipe_next[0] = 1'b1;
      rd_addr_next    = addr;
    end
    if (cmd_write | cmd_idle) begin
      off_pipe_next[0] = 1'b1;
    end
    // Fetch row one half cycle after the command
    if (rd_pipe_reg[0]) begin
      rd_row_next = mem[rd_addr_reg];
    end
    // Hand the row on before a following read overwrites it
    if (rd_pipe_reg[2]) begin
      out_row_next = rd_row_reg;
    end
    // Launch at n+2 and n+2.5; both beats always run
    if (rd_pipe_reg[3]) begin
      dq_out_next = out_row_reg[DATA_W-1:0];
    end else if (rd_pipe_reg[4]) begin
      dq_out_next = out_row_reg[2*DATA_W-1:DATA_W];
    end
    // Drivers on only for read beats; a deselect behind a read waits
    dq_oe_next = rd_pipe_reg[3] | rd_pipe_reg[4];
    if (off_pipe_reg[4]) begin
      dq_oe_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_pipe_reg  <= 5'h00;
      rd_addr_reg  <= '0;
      rd_row_reg   <= '0;
      out_row_reg  <= '0;
      dq_out_reg   <= '0;
      dq_oe_reg    <= 1'b0;
      off_pipe_reg <= 5'h00;
    end else begin
      rd_pipe_reg  <= rd_pipe_next;
      rd_addr_reg  <= rd_addr_next;
      rd_row_reg   <= rd_row_next;
      out_row_reg  <= out_row_next;
      dq_out_reg   <= dq_out_next;
      dq_oe_reg    <= dq_oe_next;
      off_pipe_reg <= off_pipe_next;
    end
  end

  // Write: command at n, beat at n+1 positive half, beat at n+1.5
  always_comb begin
    ws_next          = ws_reg;
    wr_addr_next     = wr_addr_reg;
    wr_wait_next     = wr_wait_reg;
    beat0_next       = beat0_reg;
    mask0_next       = mask0_reg;
    commit_next      = 1'b0;
    commit_data_next = commit_data_reg;
    commit_bits_next = commit_bits_reg;
    commit_addr_next = commit_addr_reg;
    pend_next        = pend_reg;
    pend_addr_next   = pend_addr_reg;
    unique case (ws_reg)
      dbs_pkg::DBS_IDLE: begin
        if (cmd_write) begin
          wr_addr_next = addr;
          wr_wait_next = 2'h1;
          ws_next      = dbs_pkg::DBS_WBEAT;
        end
      end
      dbs_pkg::DBS_WBEAT: begin
        if (wr_wait_reg != 2'h0) begin
          wr_wait_next = wr_wait_reg - 2'h1;
        end else if (cmd_edge) begin
          beat0_next = dq_in;
          mask0_next = byte_write_mask_n;
          ws_next    = dbs_pkg::DBS_WCOMM;
          // Writes every cycle: the next command shares this slot
          if (cmd_write) begin
            pend_next      = 1'b1;
            pend_addr_next = addr;
          end
        end
      end
      dbs_pkg::DBS_WCOMM: begin
        // Second beat on the negative half; commit together
        commit_data_next = {dq_in, beat0_reg};
        commit_bits_next = {lane_en(byte_write_mask_n), lane_en(mask0_reg)};
        commit_addr_next = wr_addr_reg;
        commit_next      = ~(&mask0_reg & &byte_write_mask_n);
        ws_next          = dbs_pkg::DBS_IDLE;
        // Queued write: its first beat is on the very next slot
        if (pend_reg) begin
          wr_addr_next = pend_addr_reg;
          wr_wait_next = 2'h0;
          pend_next    = 1'b0;
          ws_next      = dbs_pkg::DBS_WBEAT;
        end
      end
      default: ws_next = dbs_pkg::DBS_IDLE;
    endcase
    // Back-to-back write: next command lands on the commit slot
    if (ws_reg == dbs_pkg::DBS_WCOMM && cmd_write) begin
      wr_addr_next = addr;
      wr_wait_next = 2'h1;
      ws_next      = dbs_pkg::DBS_WBEAT;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ws_reg          <= dbs_pkg::DBS_IDLE;
      wr_addr_reg     <= '0;
      wr_wait_reg     <= 2'h0;
      beat0_reg       <= '0;
      mask0_reg       <= '1;
      commit_reg      <= 1'b0;
      commit_data_reg <= '0;
      commit_bits_reg <= '0;
      commit_addr_reg <= '0;
      pend_reg        <= 1'b0;
      pend_addr_reg   <= '0;
    end else begin
      ws_reg          <= ws_next;
      wr_addr_reg     <= wr_addr_next;
      wr_wait_reg     <= wr_wait_next;
      beat0_reg       <= beat0_next;
      mask0_reg       <= mask0_next;
      commit_reg      <= commit_next;
      commit_data_reg <= commit_data_next;
      commit_bits_reg <= commit_bits_next;
      commit_addr_reg <= commit_addr_next;
      pend_reg        <= pend_next;
      pend_addr_reg   <= pend_addr_next;
    end
  end

  // Array write, no reset: contents are undefined at power-up
  always_ff @(posedge sys_clk) begin
    if (commit_reg) begin
      mem[commit_addr_reg] <= (mem[commit_addr_reg] & ~commit_bits_reg)
                            | (commit_data_reg & commit_bits_reg);
    end
  end

  assign dq_out         = dq_out_reg;
  assign dq_oe          = dq_oe_reg;
  assign dq_term_active = ~dq_oe_reg & termination_select;

  // Checks
  read_beats_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_read |-> ##5 dq_oe ##1 dq_oe) else $error("read beats not driven");
  deselect_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_idle && !rd_pipe_reg[0] && !rd_pipe_reg[1] && !rd_pipe_reg[2]) |-> ##6 !dq_oe)
    else $error("drivers not off after deselect");
  write_abort_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ws_reg == dbs_pkg::DBS_WCOMM && &mask0_reg && &byte_write_mask_n) |=> !commit_reg)
    else $error("masked write committed");
  write_commit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ws_reg == dbs_pkg::DBS_WCOMM && !(&mask0_reg)) |=> commit_reg)
    else $error("write not committed");
  no_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_idle && ws_reg == dbs_pkg::DBS_IDLE) |=> $stable(wr_addr_reg))
    else $error("deselect loaded address");
  write_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_write && ws_reg != dbs_pkg::DBS_WBEAT) |=> wr_addr_reg == $past(addr))
    else $error("write address not captured");
  term_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
    dq_term_active |-> (termination_select && !dq_oe))
    else $error("termination while driving");
  beat_order_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_pipe_reg[4] |=> dq_out == $past(out_row_reg[2*DATA_W-1:DATA_W]))
    else $error("second beat wrong word");
  // Read side
  read_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_read |=> (rd_pipe_reg[0] && rd_addr_reg == $past(addr)))
    else $error("read not accepted");
  beat_one_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_pipe_reg[3] |=> (dq_oe && dq_out == $past(out_row_reg[DATA_W-1:0])))
    else $error("first beat wrong word");
  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!rd_pipe_reg[3] && !rd_pipe_reg[4]) |=> !dq_oe)
    else $error("driving outside read beats");
  off_slot_a: assert property (@(posedge sys_clk) disable iff (rst)
    off_pipe_reg[4] |=> !dq_oe)
    else $error("turnaround slot driven");
  term_on_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!dq_oe && termination_select) |-> dq_term_active)
    else $error("termination not shown");
  // Write side
  write_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_write && ws_reg == dbs_pkg::DBS_IDLE) |=> (ws_reg == dbs_pkg::DBS_WBEAT && wr_wait_reg == 2'h1))
    else $error("write not started");
  idle_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_idle && ws_reg == dbs_pkg::DBS_IDLE && !pend_reg) |=> ws_reg == dbs_pkg::DBS_IDLE)
    else $error("deselect started a write");
  pend_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_write && ws_reg == dbs_pkg::DBS_WBEAT) |=> (pend_reg && pend_addr_reg == $past(addr)))
    else $error("overlapping write lost");
  pend_drain_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ws_reg == dbs_pkg::DBS_WCOMM && pend_reg) |=> (ws_reg == dbs_pkg::DBS_WBEAT && wr_wait_reg == 2'h0))
    else $error("queued write not resumed");
  beat_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ws_reg == dbs_pkg::DBS_WBEAT && wr_wait_reg == 2'h0 && cmd_edge) |=> ws_reg == dbs_pkg::DBS_WCOMM)
    else $error("first beat not captured");
  beat_two_a: assert property (@(posedge sys_clk) disable iff (rst)
    ws_reg == dbs_pkg::DBS_WCOMM |=> commit_data_reg[2*DATA_W-1:DATA_W] == $past(dq_in))
    else $error("second beat not captured");
  second_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ws_reg == dbs_pkg::DBS_WCOMM && !(&byte_write_mask_n)) |=> commit_reg)
    else $error("second beat write dropped");
  commit_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    ws_reg == dbs_pkg::DBS_WCOMM |=> commit_addr_reg == $past(wr_addr_reg))
    else $error("commit address wrong");
  commit_once_a: assert property (@(posedge sys_clk) disable iff (rst)
    ws_reg == dbs_pkg::DBS_WCOMM |=> ws_reg != dbs_pkg::DBS_WCOMM)
    else $error("commit slot repeated");
endmodule : dbs_core
`default_nettype wire

// ==== dbs_ctl_model.sv ====
// Controller model: commands, late-write beats, expected read beats
`timescale 1ns/1ps
`default_nettype none
module dbs_ctl_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  output logic             beat_phase,
  output logic             load_n,
  output logic             read_not_write,
  output logic [3:0]       addr,
  output logic [3:0]       byte_write_mask_n,
  output logic [35:0]      dq_in
);
  logic [84:0] cq[$];
  logic [71:0] bq[$];
  logic [67:0] eq[$];
  logic [84:0] c;
  logic [71:0] b;
  int          tk = 0;
  initial begin
    {beat_phase, load_n, read_not_write, addr, byte_write_mask_n} = 11'h7_00;
    dq_in = 36'h0_0000_0000;
  end
  task automatic send(input logic [84:0] x);
    cq.push_back(x);
  endtask : send
  always @(posedge sys_clk) begin
    #1;
    tk++;
    beat_phase = ~beat_phase;
    // Idle pins wander so a stray load or write shows up later
    load_n = 1'b1;
    {read_not_write, addr} = 5'($urandom);
    dq_in = ~dq_in;
    byte_write_mask_n = ~byte_write_mask_n;
    if (bq.size() != 0 && bq[0][71:40] == tk) begin
      b = bq.pop_front();
      {byte_write_mask_n, dq_in} = b[39:0];
    end
    if (!rst && !beat_phase && cq.size() != 0) begin
      c = cq.pop_front();
      {read_not_write, addr} = c[84:80];
      load_n = 1'b0;
      if (c[84]) begin
        eq.push_back({32'(tk + 5), c[79:44]});
        eq.push_back({32'(tk + 6), c[39:4]});
      end else begin
        bq.push_back({32'(tk + 2), c[43:40], c[79:44]});
        bq.push_back({32'(tk + 3), c[3:0], c[39:4]});
      end
    end
  end
endmodule : dbs_ctl_model
`default_nettype wire

// ==== dbs_core_tb.sv ====
// Self-checking bench for the burst-of-two SRAM core
`timescale 1ns/1ps
`default_nettype none
module dbs_core_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        termination_select = 1'b0;
  logic        ts_chk = 1'b1;
  logic        beat_phase, load_n, read_not_write, dq_oe, dq_term_active;
  logic [3:0]  addr, byte_write_mask_n;
  logic [35:0] dq_in, dq_out;
  logic [71:0] mem [16];
  int          failures = 0;
  int          compares = 0;
  initial forever #4 sys_clk = ~sys_clk;
  dbs_ctl_model ctl (.sys_clk(sys_clk), .rst(rst), .beat_phase(beat_phase), .load_n(load_n),
    .read_not_write(read_not_write), .addr(addr), .byte_write_mask_n(byte_write_mask_n), .dq_in(dq_in));
  dbs_core #(.DATA_W(dbs_pkg::WIDTH_X36), .ADDR_W(4)) uut (.sys_clk(sys_clk), .rst(rst),
    .beat_phase(beat_phase), .load_n(load_n), .read_not_write(read_not_write), .addr(addr),
    .byte_write_mask_n(byte_write_mask_n), .termination_select(termination_select), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_term_active(dq_term_active));
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [3:0] a, input logic [35:0] d1, d2, input logic [3:0] m1, m2);
    for (int i = 0; i < 4; i++) begin
      if (!m1[i]) mem[a][9*i +: 9] = d1[9*i +: 9];
      if (!m2[i]) mem[a][36 + 9*i +: 9] = d2[9*i +: 9];
    end
    ctl.send({1'b0, a, d1, m1, d2, m2});
  endtask : wr
  task automatic rd(input logic [3:0] a);
    ctl.send({1'b1, a, mem[a][35:0], 4'h0, mem[a][71:36], 4'h0});
  endtask : rd
  task automatic drain();
    repeat (400) if (ctl.cq.size() + ctl.bq.size() + ctl.eq.size() != 0) @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
  endtask : drain
  // Reads waited on after writes: same-row read-after-write spacing is not pinned
  task automatic mix();
    logic [3:0] m;
    for (int k = 0; k < 40; k++) begin
      m = (k % 5 == 0) ? 4'hF : 4'($urandom);
      wr(4'($urandom), 36'($urandom), 36'($urandom), m, (k % 5 == 0) ? 4'hF : 4'($urandom));
    end
    drain();
    for (int r = 0; r < 16; r++) begin
      rd(4'(r));
      repeat (2 + 2 * (r % 2)) @(posedge sys_clk);
    end
    drain();
  endtask : mix
  always @(negedge sys_clk) begin : mon
    logic [67:0] e;
    if (ctl.eq.size() != 0 && ctl.eq[0][67:36] == ctl.tk) begin
      e = ctl.eq.pop_front();
      chk("dq_oe", 36'(dq_oe), 36'h0_0000_0001);
      chk("dq_out", dq_out, e[35:0]);
    end else begin
      chk("dq_oe", 36'(dq_oe), 36'h0_0000_0000);
      if (ts_chk && !rst) chk("dq_term_active", 36'(dq_term_active), 36'(termination_select));
    end
  end
  initial begin
    void'($urandom(77440));
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    for (int r = 0; r < 16; r++) wr(4'(r), 36'($urandom), 36'($urandom), 4'h0, 4'h0);
    drain();
    for (int r = 0; r < 16; r++) rd(4'(r));
    drain();
    $display("Test full rows done");
    mix();
    $display("Test masked writes done");
    ts_chk = 1'b0;
    #1 termination_select = 1'b1;
    repeat (4) @(posedge sys_clk);
    ts_chk = 1'b1;
    mix();
    $display("Test termination on done");
    finish_test();
  end
  initial begin
    #400000;
    failures++;
    finish_test();
  end
endmodule : dbs_core_tb
`default_nettype wire
